/* rtl/mcwcs_pkg.sv */
// Package for the write-credit threshold and scrub address block
package mcwcs_pkg;
   // Dword register byte offsets
   localparam logic [7:0] MCWCS_OFF_WR_THRESHOLDS = 8'h74;
   localparam logic [7:0] MCWCS_OFF_SCRUB_LOW = 8'h78;
   localparam logic [7:0] MCWCS_OFF_SCRUB_HIGH = 8'h7C;

   // Write credit thresholds fields
   localparam int MCWCS_HIGH_LSB = 8;
   localparam int MCWCS_CRIT_LSB = 0;
   localparam int MCWCS_THR_W = 5;
   localparam logic [4:0] MCWCS_HIGH_RESET = 5'h04;
   localparam logic [4:0] MCWCS_CRIT_RESET = 5'h03;

   // Scrub address low fields
   localparam int MCWCS_ROW_LSB = 14;
   localparam int MCWCS_ROW_W = 16;
   localparam int MCWCS_COL_LSB = 0;
   localparam int MCWCS_COL_W = 14;

   // Scrub address high fields
   localparam int MCWCS_CHAN_LSB = 8;
   localparam int MCWCS_DIMM_LSB = 6;
   localparam int MCWCS_RANK_LSB = 4;
   localparam int MCWCS_BANK_LSB = 0;
   localparam int MCWCS_CHAN_W = 2;
   localparam int MCWCS_DIMM_W = 2;
   localparam int MCWCS_RANK_W = 2;
   localparam int MCWCS_BANK_W = 4;
   localparam logic [31:0] MCWCS_SCRUB_RESET = 32'h0000_0000;

   // Scrub location as logged or requested
   typedef struct packed {
      logic [MCWCS_ROW_W-1:0] row;
      logic [MCWCS_COL_W-1:0] col;
      logic [MCWCS_CHAN_W-1:0] chan;
      logic [MCWCS_DIMM_W-1:0] dimm;
      logic [MCWCS_RANK_W-1:0] rank;
      logic [MCWCS_BANK_W-1:0] bank;
   } mcwcs_addr_t;

   // Configuration access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mcwcs_cfg_t;
endpackage

/* rtl/mcwcs_top.sv */
// Write-credit thresholds and patrol scrub address registers
//
// Rules for this block and for the software that drives it
// R1: Thresholds reserve write credits so lower priorities cannot take them.
// R2: Software keeps high at least critical, both below initial write credits.
// R3: Threshold writes steer credit reservation at once, no reload needed.
// R4: Software sets critical threshold to the io_hub's critical request_tag count.
// R5: Software sets high threshold to critical plus high tags, at most 30.
// R6: Software sets each isoch_entry_level to 31 minus critical threshold.
// R7: Threshold register: high bits 12:8 reset 4, critical bits 4:0 reset 3.
// R8: Low scrub register logs row 29:14 and column 13:0 of last scrub.
// R9: Memory test errors log the failing location into the scrub registers.
// R10: Written scrub address becomes next scrub location when begin_scrub_bit sets.
// R11: Software disables patrol scrub before writing the low scrub register.
// R12: Software disables scrub before reading or writing the high scrub register.
// R13: Channel bits 9:8 are software written only, never hardware logged.
// R14: High scrub register logs DIMM 7:6, rank 5:4, bank 3:0, reset zero.
// R15: Software writes DIMM and rank together as a rank identifier.
// R16: With three DIMMs, rank is bit 0, DIMM is DIMM bit 0 with rank bit 1.
`timescale 1ns/10ps
module mcwcs_top
   import mcwcs_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Dword configuration access
   input wire mcwcs_cfg_t i_cfg,
   output logic o_cfg_rvalid_q,
   output logic [31:0] o_cfg_rdata_q,
   // Write credit state
   input wire logic [4:0] i_wr_credits_free,
   output logic o_wr_allow_normal_q,
   output logic o_wr_allow_high_q,
   output logic o_wr_allow_crit_q,
   // Scrub and memory test events
   input wire logic i_scrub_issue,
   input wire mcwcs_addr_t i_scrub_issue_addr,
   input wire logic i_memtest_active,
   input wire logic i_memtest_err,
   input wire mcwcs_addr_t i_memtest_fail_addr,
   input wire logic i_begin_scrub,
   output logic o_scrub_start_q,
   output mcwcs_addr_t o_scrub_next_q
);

   function automatic logic cfg_hit(input logic [7:0] addr, input logic [7:0] off);
      cfg_hit = (addr == off);
   endfunction

   logic [4:0] thr_high_q, thr_high_d;
   logic [4:0] thr_crit_q, thr_crit_d;
   mcwcs_addr_t scrub_q, scrub_d;
   logic [31:0] rd_word;

   wire wr_thr = i_cfg.wr & cfg_hit(i_cfg.addr, MCWCS_OFF_WR_THRESHOLDS);
   wire wr_lo = i_cfg.wr & cfg_hit(i_cfg.addr, MCWCS_OFF_SCRUB_LOW);
   wire wr_hi = i_cfg.wr & cfg_hit(i_cfg.addr, MCWCS_OFF_SCRUB_HIGH);
   wire rd_thr = cfg_hit(i_cfg.addr, MCWCS_OFF_WR_THRESHOLDS);
   wire rd_lo = cfg_hit(i_cfg.addr, MCWCS_OFF_SCRUB_LOW);
   wire rd_hi = cfg_hit(i_cfg.addr, MCWCS_OFF_SCRUB_HIGH);

   // R9 memtest logging
   wire memtest_log = i_memtest_active & i_memtest_err;
   // R8 scrub logging
   wire hw_log = i_scrub_issue | memtest_log;
   // A test failure outranks a scrub in the same cycle: the failing spot matters more
   wire mcwcs_addr_t log_addr = memtest_log ? i_memtest_fail_addr : i_scrub_issue_addr;

   // R7 threshold fields
   assign thr_high_d = wr_thr ? i_cfg.wdata[MCWCS_HIGH_LSB +: MCWCS_THR_W] : thr_high_q;
   assign thr_crit_d = wr_thr ? i_cfg.wdata[MCWCS_CRIT_LSB +: MCWCS_THR_W] : thr_crit_q;

   // R8 row and column, hardware logging wins over a software write
   assign scrub_d.row = hw_log ? log_addr.row :
                        wr_lo ? i_cfg.wdata[MCWCS_ROW_LSB +: MCWCS_ROW_W] : scrub_q.row;
   assign scrub_d.col = hw_log ? log_addr.col :
                        wr_lo ? i_cfg.wdata[MCWCS_COL_LSB +: MCWCS_COL_W] : scrub_q.col;
   // R13 channel from software only
   assign scrub_d.chan = wr_hi ? i_cfg.wdata[MCWCS_CHAN_LSB +: MCWCS_CHAN_W] : scrub_q.chan;
   // R14 DIMM, rank and bank
   assign scrub_d.dimm = hw_log ? log_addr.dimm :
                         wr_hi ? i_cfg.wdata[MCWCS_DIMM_LSB +: MCWCS_DIMM_W] : scrub_q.dimm;
   assign scrub_d.rank = hw_log ? log_addr.rank :
                         wr_hi ? i_cfg.wdata[MCWCS_RANK_LSB +: MCWCS_RANK_W] : scrub_q.rank;
   assign scrub_d.bank = hw_log ? log_addr.bank :
                         wr_hi ? i_cfg.wdata[MCWCS_BANK_LSB +: MCWCS_BANK_W] : scrub_q.bank;

   // Reserved bits read as zero; unmapped offsets read zero
   assign rd_word = rd_thr ? {19'h0_0000, thr_high_q, 3'h0, thr_crit_q} :
                    rd_lo ? {2'h0, scrub_q.row, scrub_q.col} :
                    rd_hi ? {22'h00_0000, scrub_q.chan, scrub_q.dimm, scrub_q.rank, scrub_q.bank} :
                    32'h0000_0000;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         thr_high_q <= MCWCS_HIGH_RESET;
         thr_crit_q <= MCWCS_CRIT_RESET;
         scrub_q <= mcwcs_addr_t'({8'h00, MCWCS_SCRUB_RESET});
      end else begin
         thr_high_q <= thr_high_d;
         thr_crit_q <= thr_crit_d;
         scrub_q <= scrub_d;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cfg_rvalid_q <= 1'b0;
         o_cfg_rdata_q <= 32'h0000_0000;
      end else begin
         o_cfg_rvalid_q <= i_cfg.rd;
         o_cfg_rdata_q <= i_cfg.rd ? rd_word : o_cfg_rdata_q;
      end
   end

   // R1 credit reservation; R3 uses live register values
   // Grants lag the free count by one cycle, so the arbiter must not spend the same credit twice
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wr_allow_normal_q <= 1'b0;
         o_wr_allow_high_q <= 1'b0;
         o_wr_allow_crit_q <= 1'b0;
      end else begin
         o_wr_allow_normal_q <= (i_wr_credits_free > thr_high_q);
         o_wr_allow_high_q <= (i_wr_credits_free > thr_crit_q);
         o_wr_allow_crit_q <= (i_wr_credits_free != 5'h00);
      end
   end

   // R10 hand next scrub location to the scrub engine
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_scrub_start_q <= 1'b0;
         o_scrub_next_q <= mcwcs_addr_t'({8'h00, MCWCS_SCRUB_RESET});
      end else begin
         o_scrub_start_q <= i_begin_scrub;
         o_scrub_next_q <= scrub_q;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence thr_write_s;
      wr_thr;
   endsequence

   sequence log_event_s;
      i_scrub_issue && !memtest_log;
   endsequence

   sequence low_write_s;
      wr_lo && !hw_log;
   endsequence

   sequence begin_quiet_s;
      i_begin_scrub && !hw_log && !wr_lo;
   endsequence

   thr_write_take_a: assert property (thr_write_s |=> // R7
      (thr_high_q == $past(i_cfg.wdata[MCWCS_HIGH_LSB +: MCWCS_THR_W]))
      && (thr_crit_q == $past(i_cfg.wdata[MCWCS_CRIT_LSB +: MCWCS_THR_W])))
      else $error("threshold write not taken");
   thr_immediate_a: assert property (thr_write_s ##1 1'b1 |=> o_wr_allow_normal_q == // R3
      ($past(i_wr_credits_free) > $past(i_cfg.wdata[MCWCS_HIGH_LSB +: MCWCS_THR_W], 2)))
      else $error("new high threshold not in effect");
   normal_reserve_a: assert property (o_wr_allow_normal_q |-> $past(i_wr_credits_free) > $past(thr_high_q)) // R1
      else $error("normal write took a reserved credit");
   high_reserve_a: assert property (##1 o_wr_allow_high_q == ($past(i_wr_credits_free) > $past(thr_crit_q))) // R1
      else $error("high write reservation wrong");
   scrub_row_log_a: assert property (log_event_s |=> scrub_q.row == $past(i_scrub_issue_addr.row) // R8
      && scrub_q.col == $past(i_scrub_issue_addr.col))
      else $error("scrub row or column not logged");
   memtest_log_a: assert property (memtest_log |=> scrub_q.bank == $past(i_memtest_fail_addr.bank) // R9
      && scrub_q.row == $past(i_memtest_fail_addr.row))
      else $error("memtest failing address not logged");
   chan_sw_only_a: assert property (!wr_hi |=> $stable(scrub_q.chan)) // R13
      else $error("channel changed without a write");
   bank_log_a: assert property (log_event_s |=> scrub_q.bank == $past(i_scrub_issue_addr.bank) // R14
      && scrub_q.dimm == $past(i_scrub_issue_addr.dimm) && scrub_q.rank == $past(i_scrub_issue_addr.rank))
      else $error("bank, rank or DIMM not logged");
   // Bus writes leave one idle cycle before the start pulse can follow
   scrub_start_a: assert property (low_write_s ##1 !hw_log && !wr_lo ##1 begin_quiet_s |=> // R10
      o_scrub_start_q && o_scrub_next_q.row == $past(i_cfg.wdata[MCWCS_ROW_LSB +: MCWCS_ROW_W], 3))
      else $error("written scrub address not used as next");
   thr_read_a: assert property (i_cfg.rd && rd_thr |=> o_cfg_rvalid_q // R7
      && o_cfg_rdata_q == {19'h0_0000, $past(thr_high_q), 3'h0, $past(thr_crit_q)})
      else $error("threshold readback wrong");

   // R1 critical grant needs one credit
   crit_grant_a: assert property (##1 o_wr_allow_crit_q == ($past(i_wr_credits_free) != 5'h00)) // R1
      else $error("critical write grant wrong");
   normal_grant_a: assert property (##1 o_wr_allow_normal_q == // R1
      ($past(i_wr_credits_free) > $past(thr_high_q)))
      else $error("normal write grant wrong");
   // R3 thresholds move on writes only
   thr_hold_a: assert property (!wr_thr |=> $stable(thr_high_q) && $stable(thr_crit_q)) // R3
      else $error("threshold changed without a write");
   read_valid_a: assert property (##1 o_cfg_rvalid_q == $past(i_cfg.rd)) // R7
      else $error("read valid not one cycle after request");
   low_read_a: assert property (i_cfg.rd && rd_lo |=> o_cfg_rdata_q == // R8
      {2'h0, $past(scrub_q.row), $past(scrub_q.col)})
      else $error("low scrub readback wrong");
   high_read_a: assert property (i_cfg.rd && rd_hi |=> o_cfg_rdata_q == {22'h00_0000, // R14
      $past(scrub_q.chan), $past(scrub_q.dimm), $past(scrub_q.rank), $past(scrub_q.bank)})
      else $error("high scrub readback wrong");
   // R9 errors outside a test run are ignored
   memtest_idle_a: assert property (i_memtest_err && !i_memtest_active && !i_scrub_issue && !wr_lo |=> // R9
      $stable(scrub_q.row) && $stable(scrub_q.col))
      else $error("error logged outside memory test");
   memtest_wins_a: assert property (memtest_log && i_scrub_issue |=> // R9
      scrub_q.col == $past(i_memtest_fail_addr.col)
      && scrub_q.dimm == $past(i_memtest_fail_addr.dimm) && scrub_q.rank == $past(i_memtest_fail_addr.rank))
      else $error("memtest address lost to scrub address");
   // R10 written location becomes next target
   low_write_a: assert property (low_write_s |=> // R10
      scrub_q.row == $past(i_cfg.wdata[MCWCS_ROW_LSB +: MCWCS_ROW_W])
      && scrub_q.col == $past(i_cfg.wdata[MCWCS_COL_LSB +: MCWCS_COL_W]))
      else $error("low scrub write not taken");
   high_write_a: assert property (wr_hi && !hw_log |=> // R14
      scrub_q.bank == $past(i_cfg.wdata[MCWCS_BANK_LSB +: MCWCS_BANK_W])
      && scrub_q.dimm == $past(i_cfg.wdata[MCWCS_DIMM_LSB +: MCWCS_DIMM_W])
      && scrub_q.rank == $past(i_cfg.wdata[MCWCS_RANK_LSB +: MCWCS_RANK_W]))
      else $error("high scrub write not taken");
   chan_write_a: assert property (wr_hi |=> // R13
      scrub_q.chan == $past(i_cfg.wdata[MCWCS_CHAN_LSB +: MCWCS_CHAN_W]))
      else $error("channel write not taken");
   scrub_pulse_a: assert property (##1 o_scrub_start_q == $past(i_begin_scrub)) // R10
      else $error("scrub start pulse misplaced");
   scrub_next_a: assert property (i_begin_scrub |=> o_scrub_next_q == $past(scrub_q)) // R10
      else $error("next scrub location not handed over");

endmodule

/* bench/mcwcs_bench.sv */
// Self-checking bench for the write-credit threshold and scrub address block
`timescale 1ns/10ps
module mcwcs_bench;
   import mcwcs_pkg::*;
   logic i_sys_clk, i_rst_n, rvalid, an, ah, ac, s_issue, mt_act, mt_err, begin_s, start;
   logic [31:0] rdata, seed, exp_lo, exp_hi, t;
   logic [63:0] w;
   logic [4:0] free, h, c;
   mcwcs_cfg_t cfg;
   mcwcs_addr_t s_addr, mt_addr, nxt;
   int mismatches, checked;
   mcwcs_top mcwcs_top_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cfg(cfg), .o_cfg_rvalid_q(rvalid),
      .o_cfg_rdata_q(rdata), .i_wr_credits_free(free), .o_wr_allow_normal_q(an), .o_wr_allow_high_q(ah),
      .o_wr_allow_crit_q(ac), .i_scrub_issue(s_issue), .i_scrub_issue_addr(s_addr), .i_memtest_active(mt_act),
      .i_memtest_err(mt_err), .i_memtest_fail_addr(mt_addr), .i_begin_scrub(begin_s), .o_scrub_start_q(start),
      .o_scrub_next_q(nxt));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
      checked++;
      if (exp !== got) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(negedge i_sys_clk) cfg.wr = 1'b1;
      cfg.addr = a;
      cfg.wdata = d;
      @(negedge i_sys_clk) cfg.wr = 1'b0;
   endtask
   // Read answer lands one cycle after the request
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      @(negedge i_sys_clk) cfg.rd = 1'b1;
      cfg.addr = a;
      @(negedge i_sys_clk) cfg.rd = 1'b0;
      chk("rvalid", 64'h1, {63'h0, rvalid});
      chk("rdata", {32'h0, exp}, {32'h0, rdata});
   endtask
   task automatic bs();
      @(negedge i_sys_clk) begin_s = 1'b1;
      @(negedge i_sys_clk) begin_s = 1'b0;
      chk("start", 64'h1, {63'h0, start});
      chk("next", {24'h0, exp_lo[29:0], exp_hi[9:0]}, {24'h0, nxt});
      @(negedge i_sys_clk) chk("start_low", 64'h0, {63'h0, start});
   endtask
   task automatic results();
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   // Limit is about thirty times the expected run length
   initial begin
      #25000;
      mismatches++;
      results();
   end
   initial begin
      {i_rst_n, s_issue, mt_act, mt_err, begin_s, free} = '0;
      cfg = '0;
      s_addr = '0;
      mt_addr = '0;
      seed = 32'h7DF1;
      repeat (12) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      rd(MCWCS_OFF_WR_THRESHOLDS, 32'h0000_0403);
      rd(MCWCS_OFF_SCRUB_LOW, 32'h0);
      rd(MCWCS_OFF_SCRUB_HIGH, 32'h0);
      rd(8'h80, 32'h0);
      for (int i = 0; i < 24; i++) begin
         t = rnd();
         // high at least critical, high at most 30
         h = (t[4:0] == 5'h1F) ? 5'h1E : t[4:0];
         c = (t[12:8] > h) ? h : t[12:8];
         // the queue entry level of 31 minus c is set outside this block
         wr(MCWCS_OFF_WR_THRESHOLDS, {19'h0, h, 3'h0, c});
         t = rnd();
         free = (i % 4 == 0) ? h : (i % 4 == 1) ? c : (i % 4 == 2) ? 5'h00 : t[4:0];
         @(negedge i_sys_clk) chk("allow", {61'h0, free > h, free > c, free != 5'h00}, {61'h0, an, ah, ac});
      end
      rd(MCWCS_OFF_WR_THRESHOLDS, {19'h0, h, 3'h0, c});
      t = rnd();
      exp_lo = t & 32'h3FFF_FFFF;
      exp_hi = rnd() & 32'h0000_03FF;
      // no scrub or test event runs around these accesses
      // reads stay raw; the three-DIMM translation is left to software
      wr(MCWCS_OFF_SCRUB_HIGH, exp_hi | 32'hFFFF_FC00);
      rd(MCWCS_OFF_SCRUB_HIGH, exp_hi);
      // Low write just before the start pulse exercises the hand-over
      wr(MCWCS_OFF_SCRUB_LOW, t);
      bs();
      for (int i = 0; i < 9; i++) begin
         w = {rnd(), rnd()};
         @(negedge i_sys_clk) s_addr = w[39:0];
         w = {rnd(), rnd()};
         mt_addr = w[39:0];
         s_issue = (i % 3 != 1);
         mt_err = (i % 3 != 0);
         mt_act = (i % 3 == 2);
         @(negedge i_sys_clk) {s_issue, mt_err, mt_act} = 3'b000;
         w[39:0] = (i % 3 == 2) ? mt_addr : (i % 3 == 0) ? s_addr : {exp_lo[29:0], exp_hi[9:0]};
         exp_lo = {2'h0, w[39:10]};
         exp_hi = {22'h0, exp_hi[9:8], w[7:0]};
         rd(MCWCS_OFF_SCRUB_LOW, exp_lo);
         rd(MCWCS_OFF_SCRUB_HIGH, exp_hi);
      end
      bs();
      results();
   end
endmodule
